// [logic/sbu_pkg.sv]
`default_nettype none
package sbu_pkg;
	// clock and line rates
	localparam int unsigned SBU_CLK_HZ = 10_000_000;
	localparam int unsigned SBU_BAUD_DEFAULT = 115200;
	localparam int unsigned SBU_BAUD_MIN = 9600;
	localparam int unsigned SBU_BAUD_MAX = 921600;
	localparam int SBU_DIV_W = 11;
	// clock cycles per bit, rounded to nearest
	localparam logic [SBU_DIV_W-1:0] SBU_DIV_DEFAULT = SBU_DIV_W'((SBU_CLK_HZ + SBU_BAUD_DEFAULT / 2) / SBU_BAUD_DEFAULT);
	localparam logic [SBU_DIV_W-1:0] SBU_DIV_FAST = SBU_DIV_W'((SBU_CLK_HZ + SBU_BAUD_MAX / 2) / SBU_BAUD_MAX);
	localparam logic [SBU_DIV_W-1:0] SBU_DIV_SLOW = SBU_DIV_W'((SBU_CLK_HZ + SBU_BAUD_MIN / 2) / SBU_BAUD_MIN);
	// character framing: 8N1
	localparam int SBU_DATA_BITS = 8;
	localparam logic [2:0] SBU_LAST_BIT = 3'h7;
	// receive buffer
	localparam int SBU_FIFO_DEPTH = 32;
	localparam int SBU_LEVEL_W = 6;
	// register byte offsets
	localparam logic [7:0] SBU_OFS_CTRL = 8'h00;
	localparam logic [7:0] SBU_OFS_DIV = 8'h04;
	localparam logic [7:0] SBU_OFS_STATUS = 8'h08;
	// control fields
	localparam int SBU_CTRL_OUT_BIT = 0;
	localparam int SBU_CTRL_IN_BIT = 1;
	localparam logic [1:0] SBU_CTRL_RESET = 2'h0;
	// status fields
	localparam int SBU_ST_TXBUSY = 0;
	localparam int SBU_ST_FULL = 1;
	localparam int SBU_ST_OVERRUN = 2;
	localparam int SBU_ST_FRAMING = 3;
	localparam int SBU_ST_GATE = 4;
	localparam int SBU_ST_RTR = 5;
	localparam int SBU_ST_SOCKET = 6;
	localparam int SBU_ST_LEVEL_LSB = 8;
	// synchronised pin order {gate, receive ready, rxd} and their reset levels
	localparam int SBU_PIN_RXD = 0;
	localparam int SBU_PIN_RTR = 1;
	localparam int SBU_PIN_GATE = 2;
	localparam logic [2:0] SBU_PIN_RESET = 3'h1;

	// flow-control setting
	typedef enum logic [1:0] {
		SBU_HS_DISABLED = 2'h0,
		SBU_HS_OUTBOUND = 2'h1,
		SBU_HS_INBOUND = 2'h2,
		SBU_HS_BOTH = 2'h3
	} sbu_hs_e;

	// serialiser states
	typedef enum logic [3:0] {
		SBU_SER_IDLE = 4'h1,
		SBU_SER_START = 4'h2,
		SBU_SER_DATA = 4'h4,
		SBU_SER_STOP = 4'h8
	} sbu_ser_e;

	// byte stream carrier
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sbu_stream_s;
endpackage
`default_nettype wire

// [logic/sbu_bridge.sv]
// How it works
// R1 - after reset: 115200 baud, 8 data bits, no parity, one stop, no handshake
// R2 - bit rate is programmable from 9600 to 921600 bits per second
// R3 - handshake setting: disabled, outbound-only, inbound-only or both
// R4 - send permit is driven to target, receive ready sampled from target
// R5 - outbound handshake drops send permit while receive buffer is full
// R6 - target stops sending while send permit is low
// R7 - inbound handshake sends to target only while receive ready is high
// R8 - a character already started is finished, later ones held off
// R9 - target accepts one more character after dropping receive ready
// R10 - disabled: permit undriven, receive ready ignored
// R11 - outbound-only: permit from buffer full, receive ready ignored
// R12 - inbound-only: permit undriven, transmission gated on receive ready
// R13 - both: permit from buffer full and transmission gated on receive ready
// R14 - traffic passes only while the bridge gate is high
// R15 - target bytes go to active host channel, host bytes to target
// R16 - connected socket takes all traffic, usb channel idle
// R17 - target drives receive ready before inbound handshake is enabled
// R18 - low start bit, data lsb first, high stop bit, line idles high
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

// synchronous fifo, count based
module sbu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int LW = 6
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [LW-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [LW-1:0] count_q;
	logic push;
	logic pop;

	// handshake terms
	assign inReady = count_q != LW'(DEPTH);
	assign outValid = count_q != '0;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr_q];
	assign level = count_q;

	// storage
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

	// pointers and fill count
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= wrPtr_q + AW'(1);
			if (pop)
				rdPtr_q <= rdPtr_q + AW'(1);
			if (push && !pop)
				count_q <= count_q + LW'(1);
			else if (pop && !push)
				count_q <= count_q - LW'(1);
		end
	end
endmodule

module sbu_bridge (
	input wire logic mclk,
	input wire logic srst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// target pins
	input wire logic targetRxd,
	output logic targetTxd,
	output logic targetSendPermit,
	output logic targetSendPermitOe,
	input wire logic targetReceiveReady,
	input wire logic serialBridgeGate,
	// host channels
	input wire logic socketConnected,
	input wire sbu_pkg::sbu_stream_s usbIn,
	output logic usbInReady,
	input wire sbu_pkg::sbu_stream_s sockIn,
	output logic sockInReady,
	output logic [7:0] hostOutData,
	output logic usbOutValid,
	input wire logic usbOutReady,
	output logic sockOutValid,
	input wire logic sockOutReady
);
	import sbu_pkg::*;

	// register decode shared by read and write paths
	function automatic logic [2:0] regSel(input logic [31:0] a);
		regSel = {a[7:0] == SBU_OFS_STATUS, a[7:0] == SBU_OFS_DIV, a[7:0] == SBU_OFS_CTRL};
		if (a[31:8] != '0)
			regSel = 3'h0;
	endfunction

	// keep divisor inside the supported bit-rate range
	function automatic logic [SBU_DIV_W-1:0] clampDiv(input logic [31:0] v);
		if (v < 32'(SBU_DIV_FAST))
			clampDiv = SBU_DIV_FAST;
		else if (v > 32'(SBU_DIV_SLOW))
			clampDiv = SBU_DIV_SLOW;
		else
			clampDiv = v[SBU_DIV_W-1:0];
	endfunction

	logic [2:0] pinS1_q, pinS2_q, pinS3_q, pinF_q;
	logic [2:0] pinRaw;
	logic rxdF, rtrF, gateF;
	sbu_hs_e hsMode_q;
	logic [SBU_DIV_W-1:0] div_q;
	logic wrPend_q;
	logic [2:0] wrSel_q;
	logic overrun_q, framing_q;
	logic [31:0] statusWord;
	logic [31:0] readWord;
	logic addrPhase;
	sbu_ser_e rxState_q, txState_q;
	logic [SBU_DIV_W-1:0] rxCnt_q, txCnt_q;
	logic [2:0] rxBit_q, txBit_q;
	logic [7:0] rxShift_q, txShift_q;
	logic rxPush_q;
	logic fifoInReady, fifoOutValid, fifoPop;
	logic [7:0] fifoOutData;
	logic [SBU_LEVEL_W-1:0] fifoLevel;
	logic [7:0] hold_q;
	logic holdValid_q;
	logic hostAccept, txStart, holdNext;
	logic outHeld_q, outTake, outLoad, outHeldNext;

	// three-stage synchronisers, a change counts once stages two and three agree
	assign pinRaw = {serialBridgeGate, targetReceiveReady, targetRxd};
	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		always_ff @(posedge mclk)
		begin
			if (srst)
			begin
				pinS1_q[i] <= SBU_PIN_RESET[i];
				pinS2_q[i] <= SBU_PIN_RESET[i];
				pinS3_q[i] <= SBU_PIN_RESET[i];
				pinF_q[i] <= SBU_PIN_RESET[i];
			end
			else
			begin
				pinS1_q[i] <= pinRaw[i];
				pinS2_q[i] <= pinS1_q[i];
				pinS3_q[i] <= pinS2_q[i];
				if (pinS2_q[i] == pinS3_q[i])
					pinF_q[i] <= pinS3_q[i];
			end
		end
	end
	assign rxdF = pinF_q[SBU_PIN_RXD];
	assign rtrF = pinF_q[SBU_PIN_RTR];
	assign gateF = pinF_q[SBU_PIN_GATE];

	// ahb-lite: zero wait states, always okay, read data latched at address phase
	assign addrPhase = hsel && htrans[1] && hready;
	assign statusWord = {16'h0, 2'h0, fifoLevel, 1'b0, socketConnected, rtrF, gateF,
		framing_q, overrun_q, !fifoInReady, !txState_q[0]};
	always_comb
	begin
		unique case (regSel(haddr))
			3'h1: readWord = {30'h0, hsMode_q};
			3'h2: readWord = {21'h0, div_q};
			3'h4: readWord = statusWord;
			default: readWord = 32'h0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wrPend_q <= 1'b0;
			wrSel_q <= 3'h0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_q <= addrPhase && hwrite;
			if (addrPhase)
			begin
				wrSel_q <= regSel(haddr);
				hrdata <= hwrite ? 32'h0 : readWord;
			end
		end
	end

	// configuration registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hsMode_q <= sbu_hs_e'(SBU_CTRL_RESET); // R1
			div_q <= SBU_DIV_DEFAULT; // R1
		end
		else if (wrPend_q)
		begin
			if (wrSel_q[0])
				hsMode_q <= sbu_hs_e'(hwdata[1:0]); // R3
			if (wrSel_q[1])
				div_q <= clampDiv(hwdata); // R2
		end
	end

	// sticky error flags, write one to clear, a new event beats the clear
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			overrun_q <= 1'b0;
			framing_q <= 1'b0;
		end
		else
		begin
			if (rxPush_q && !fifoInReady)
				overrun_q <= 1'b1;
			else if (wrPend_q && wrSel_q[2] && hwdata[SBU_ST_OVERRUN])
				overrun_q <= 1'b0;
			if (rxState_q == SBU_SER_STOP && rxCnt_q == '0 && !rxdF)
				framing_q <= 1'b1;
			else if (wrPend_q && wrSel_q[2] && hwdata[SBU_ST_FRAMING])
				framing_q <= 1'b0;
		end
	end

	// receiver: mid-bit sampling, lsb first, stop bit checked
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rxState_q <= SBU_SER_IDLE;
			rxCnt_q <= '0;
			rxBit_q <= 3'h0;
			rxShift_q <= 8'h0;
			rxPush_q <= 1'b0;
		end
		else
		begin
			rxPush_q <= 1'b0;
			if (rxCnt_q != '0)
				rxCnt_q <= rxCnt_q - SBU_DIV_W'(1);
			unique case (rxState_q)
				SBU_SER_IDLE:
					if (!rxdF && gateF) // R14 R18
					begin
						rxCnt_q <= div_q >> 1;
						rxState_q <= SBU_SER_START;
					end
				SBU_SER_START:
					if (rxCnt_q == '0)
					begin
						rxCnt_q <= div_q - SBU_DIV_W'(1);
						rxBit_q <= 3'h0;
						rxState_q <= rxdF ? SBU_SER_IDLE : SBU_SER_DATA;
					end
				SBU_SER_DATA:
					if (rxCnt_q == '0)
					begin
						rxShift_q <= {rxdF, rxShift_q[7:1]}; // R18
						rxCnt_q <= div_q - SBU_DIV_W'(1);
						rxBit_q <= rxBit_q + 3'h1;
						if (rxBit_q == SBU_LAST_BIT)
							rxState_q <= SBU_SER_STOP;
					end
				SBU_SER_STOP:
					if (rxCnt_q == '0)
					begin
						rxPush_q <= rxdF && gateF; // R14 R15
						rxState_q <= SBU_SER_IDLE;
					end
			endcase
		end
	end

	// receive buffer toward the host
	sbu_fifo #(
		.WIDTH(SBU_DATA_BITS),
		.DEPTH(SBU_FIFO_DEPTH),
		.LW(SBU_LEVEL_W)
	) u_rxFifo (
		.mclk(mclk),
		.srst(srst),
		.inValid(rxPush_q),
		.inReady(fifoInReady),
		.inData(rxShift_q),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData),
		.level(fifoLevel)
	);

	// send permit follows buffer room, driven only with outbound handshake
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			targetSendPermit <= 1'b0;
			targetSendPermitOe <= 1'b0; // R1
		end
		else
		begin
			targetSendPermit <= fifoInReady; // R4 R5 R11 R13
			targetSendPermitOe <= hsMode_q[SBU_CTRL_OUT_BIT]; // R10 R12
		end
	end

	// host output stage, routed to socket when connected
	assign outTake = (usbOutValid && usbOutReady) || (sockOutValid && sockOutReady);
	assign outLoad = (!outHeld_q || outTake) && fifoOutValid;
	assign fifoPop = outLoad;
	assign outHeldNext = outLoad || (outHeld_q && !outTake);
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			outHeld_q <= 1'b0;
			hostOutData <= 8'h0;
			usbOutValid <= 1'b0;
			sockOutValid <= 1'b0;
		end
		else
		begin
			outHeld_q <= outHeldNext;
			if (outLoad)
				hostOutData <= fifoOutData; // R15
			usbOutValid <= outHeldNext && !socketConnected; // R16
			sockOutValid <= outHeldNext && socketConnected; // R16
		end
	end

	// host input: one byte held for the transmitter
	assign txStart = holdValid_q && txState_q == SBU_SER_IDLE && gateF
		&& (!hsMode_q[SBU_CTRL_IN_BIT] || rtrF); // R7 R10 R12 R13 R14 R17
	assign hostAccept = (usbInReady && usbIn.valid) || (sockInReady && sockIn.valid);
	assign holdNext = hostAccept || (holdValid_q && !txStart);
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			holdValid_q <= 1'b0;
			hold_q <= 8'h0;
			usbInReady <= 1'b0;
			sockInReady <= 1'b0;
		end
		else
		begin
			holdValid_q <= holdNext;
			if (hostAccept)
				hold_q <= sockInReady ? sockIn.data : usbIn.data; // R15
			usbInReady <= !holdNext && !socketConnected; // R16
			sockInReady <= !holdNext && socketConnected; // R16
		end
	end

	// transmitter: once started a character always completes
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			txState_q <= SBU_SER_IDLE;
			txCnt_q <= '0;
			txBit_q <= 3'h0;
			txShift_q <= 8'h0;
			targetTxd <= 1'b1; // R18
		end
		else
		begin
			if (txCnt_q != '0)
				txCnt_q <= txCnt_q - SBU_DIV_W'(1);
			unique case (txState_q)
				SBU_SER_IDLE:
					if (txStart)
					begin
						txShift_q <= hold_q;
						targetTxd <= 1'b0; // R18
						txCnt_q <= div_q - SBU_DIV_W'(1);
						txState_q <= SBU_SER_START;
					end
				SBU_SER_START:
					if (txCnt_q == '0)
					begin
						targetTxd <= txShift_q[0];
						txShift_q <= txShift_q >> 1;
						txBit_q <= 3'h0;
						txCnt_q <= div_q - SBU_DIV_W'(1);
						txState_q <= SBU_SER_DATA;
					end
				SBU_SER_DATA:
					if (txCnt_q == '0)
					begin
						txCnt_q <= div_q - SBU_DIV_W'(1);
						if (txBit_q == SBU_LAST_BIT)
						begin
							targetTxd <= 1'b1; // R8 R18
							txState_q <= SBU_SER_STOP;
						end
						else
						begin
							targetTxd <= txShift_q[0];
							txShift_q <= txShift_q >> 1;
							txBit_q <= txBit_q + 3'h1;
						end
					end
				SBU_SER_STOP:
					if (txCnt_q == '0)
						txState_q <= SBU_SER_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [verif/sbu_target_model.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural target uart with flow control
module sbu_target_model (
	input wire logic mclk,
	input wire logic [10:0] bitLen,
	input wire logic bridgeTxd,
	input wire logic sendPermit,
	input wire logic sendPermitOe,
	input wire logic holdOff,
	output logic txd,
	output logic receiveReady
);
	logic [7:0] rxQ[$];
	logic [7:0] sh;
	// ready pin driven from the start, dropped on request
	assign receiveReady = !holdOff;
	initial txd = 1'b1;
	// one 8n1 character; an undriven permit reads as pulled up
	task automatic send(input logic [7:0] b);
		while (sendPermitOe && !sendPermit) @(posedge mclk);
		txd <= 1'b0;
		repeat (bitLen) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			txd <= b[i];
			repeat (bitLen) @(posedge mclk);
		end
		txd <= 1'b1;
		repeat (bitLen) @(posedge mclk);
	endtask
	// receiver keeps running while ready is low
	initial forever
	begin
		@(negedge bridgeTxd);
		repeat (bitLen / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bitLen) @(posedge mclk);
			sh[i] = bridgeTxd;
		end
		repeat (bitLen) @(posedge mclk);
		if (bridgeTxd) rxQ.push_back(sh);
	end
endmodule
`default_nettype wire

// [verif/sbu_bridge_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module sbu_bridge_sva
	import sbu_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic targetTxd,
	input wire logic targetSendPermit,
	input wire logic socketConnected,
	input wire sbu_pkg::sbu_stream_s usbIn,
	input wire logic usbInReady,
	input wire logic sockInReady,
	input wire logic [7:0] hostOutData,
	input wire logic usbOutValid,
	input wire logic usbOutReady,
	input wire logic sockOutValid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	low_run_a: assert property ($fell(targetTxd) |-> !targetTxd[*8]) else $error("short low cell");
	high_run_a: assert property ($rose(targetTxd) |-> targetTxd[*8]) else $error("short high cell");
	sock_excl_a: assert property (socketConnected[*2] |-> !usbOutValid && !usbInReady) else $error("usb active");
	usb_excl_a: assert property (!socketConnected[*2] |-> !sockOutValid && !sockInReady) else $error("sock active");
	permit_full_a: assert property (!targetSendPermit && !$past(srst) |-> usbOutValid || sockOutValid)
		else $error("permit low with empty buffer");
	hold_out_a: assert property (usbOutValid && !usbOutReady && !socketConnected
		|=> socketConnected || usbOutValid && $stable(hostOutData)) else $error("host byte lost");
	take_in_a: assert property (usbIn.valid && usbInReady |=> !usbInReady) else $error("ready held");
endmodule
bind sbu_bridge sbu_bridge_sva sbu_bridge_sva_i (.mclk, .srst, .hreadyout, .hresp, .targetTxd, .targetSendPermit,
	.socketConnected, .usbIn, .usbInReady, .sockInReady, .hostOutData, .usbOutValid, .usbOutReady, .sockOutValid);
`default_nettype wire

// [verif/tb_sbu_bridge.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_sbu_bridge;
	import sbu_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, gate = 1'b1, sockOn = 1'b0, usbOutReady = 1'b1, holdOff = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
	logic [1:0] htrans = 2'h0;
	logic [10:0] bitLen = SBU_DIV_DEFAULT;
	logic hreadyout, hresp, rxd, txd, rtr, permit, permitOe, usbInReady, sockInReady, usbOutValid, sockOutValid;
	logic [7:0] hostOut;
	logic [7:0] hostQ[$], sockQ[$];
	sbu_stream_s usbIn = '0, sockIn = '0;
	int badCount = 0, cmpCount = 0, cyc = 0, n;
	initial forever #50 mclk = ~mclk;
	sbu_bridge sbu_bridge_i (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.targetRxd(rxd), .targetTxd(txd), .targetSendPermit(permit), .targetSendPermitOe(permitOe),
		.targetReceiveReady(rtr), .serialBridgeGate(gate), .socketConnected(sockOn), .usbIn(usbIn),
		.usbInReady(usbInReady), .sockIn(sockIn), .sockInReady(sockInReady), .hostOutData(hostOut),
		.usbOutValid(usbOutValid), .usbOutReady(usbOutReady), .sockOutValid(sockOutValid), .sockOutReady(1'b1));
	sbu_target_model sbu_target_model_i (.mclk(mclk), .bitLen(bitLen), .bridgeTxd(txd), .sendPermit(permit),
		.sendPermitOe(permitOe), .holdOff(holdOff), .txd(rxd), .receiveReady(rtr));
	// collect bytes handed to either host channel, and cut a hang short
	always @(posedge mclk)
	begin
		if (usbOutValid && usbOutReady) hostQ.push_back(hostOut);
		if (sockOutValid) sockQ.push_back(hostOut);
		cyc++;
		if (cyc == 30000)
		begin
			badCount++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		if (badCount == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			badCount++;
			$display("ERROR %0t saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkq(ref logic [7:0] q[$], input logic [7:0] e);
		chk({24'h0, q.size() > 0 ? q.pop_front() : 8'hxx}, {24'h0, e});
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
	endtask
	// single ahb-lite transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, st);
		chk(st, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, st);
	endtask
	task automatic hsend(input logic [7:0] b);
		usbIn <= {1'b1, b};
		do @(posedge mclk); while (usbInReady !== 1'b1);
		usbIn <= '0;
		@(posedge mclk);
	endtask
	// one host byte offered on the socket channel
	task automatic ssend(input logic [7:0] b);
		sockIn <= {1'b1, b};
		do @(posedge mclk); while (sockInReady !== 1'b1);
		sockIn <= '0;
		@(posedge mclk);
	endtask
	// reset values, one character at the reset rate, divisor clamping
	task automatic s_reset;
		rd(SBU_OFS_CTRL, 32'h0);
		rd(SBU_OFS_DIV, 32'(SBU_DIV_DEFAULT));
		rd(8'h10, 32'h0);
		chk(32'(permitOe), 32'h0);
		hsend(8'hc3);
		wt(11 * SBU_DIV_DEFAULT);
		chkq(sbu_target_model_i.rxQ, 8'hc3);
		wr(SBU_OFS_DIV, 32'h7ff);
		rd(SBU_OFS_DIV, 32'(SBU_DIV_SLOW));
		wr(SBU_OFS_DIV, 32'h0);
		rd(SBU_OFS_DIV, 32'(SBU_DIV_FAST));
		bitLen <= SBU_DIV_FAST;
	endtask
	// both directions, usb then socket, ready pin ignored
	task automatic s_path;
		holdOff <= 1'b1;
		hsend(8'h5a);
		wt(130);
		chkq(sbu_target_model_i.rxQ, 8'h5a);
		sbu_target_model_i.send(8'h3c);
		wt(30);
		chkq(hostQ, 8'h3c);
		sockOn <= 1'b1;
		sbu_target_model_i.send(8'h96);
		wt(30);
		chkq(sockQ, 8'h96);
		chk(hostQ.size(), 0);
		chk(32'(usbInReady), 32'h0);
		// host byte through the socket while a usb byte waits unserved
		usbIn <= {1'b1, 8'h11};
		ssend(8'ha5);
		wt(130);
		chkq(sbu_target_model_i.rxQ, 8'ha5);
		chk(sbu_target_model_i.rxQ.size(), 0);
		usbIn <= '0;
		sockOn <= 1'b0;
		holdOff <= 1'b0;
	endtask
	// ready dropped mid character in inbound mode
	task automatic s_in;
		wr(SBU_OFS_CTRL, 32'(SBU_HS_INBOUND));
		wt(4);
		hsend(8'h81);
		hsend(8'h82);
		holdOff <= 1'b1;
		wt(300);
		chkq(sbu_target_model_i.rxQ, 8'h81);
		chk(sbu_target_model_i.rxQ.size(), 0);
		holdOff <= 1'b0;
		wt(130);
		chkq(sbu_target_model_i.rxQ, 8'h82);
	endtask
	// fill the buffer until the permit drops, then drain it
	task automatic s_full;
		wr(SBU_OFS_CTRL, 32'(SBU_HS_OUTBOUND));
		holdOff <= 1'b1;
		hsend(8'he7);
		wt(130);
		chkq(sbu_target_model_i.rxQ, 8'he7);
		chk(32'(permitOe), 32'h1);
		usbOutReady <= 1'b0;
		for (n = 0; n < 40 && permit; n++)
		begin
			sbu_target_model_i.send(8'(n));
			wt(8);
		end
		chk(32'(permit), 32'h0);
		bus(1'b0, SBU_OFS_STATUS, 32'h0, st);
		chk({26'h0, st[13:8]}, 32'(SBU_FIFO_DEPTH));
		chk({24'h0, st[7:0]}, 32'((1 << SBU_ST_FULL) | (1 << SBU_ST_GATE)));
		// permit released: target sends into the full buffer, byte dropped, overrun flagged
		wr(SBU_OFS_CTRL, 32'(SBU_HS_DISABLED));
		sbu_target_model_i.send(8'hff);
		wt(8);
		rd(SBU_OFS_STATUS, 32'((SBU_FIFO_DEPTH << SBU_ST_LEVEL_LSB) | (1 << SBU_ST_FULL)
			| (1 << SBU_ST_OVERRUN) | (1 << SBU_ST_GATE)));
		wr(SBU_OFS_STATUS, 32'(1 << SBU_ST_OVERRUN));
		rd(SBU_OFS_STATUS, 32'((SBU_FIFO_DEPTH << SBU_ST_LEVEL_LSB) | (1 << SBU_ST_FULL)
			| (1 << SBU_ST_GATE)));
		wr(SBU_OFS_CTRL, 32'(SBU_HS_BOTH));
		hsend(8'h18);
		wt(200);
		chk(sbu_target_model_i.rxQ.size(), 0);
		holdOff <= 1'b0;
		usbOutReady <= 1'b1;
		wt(150);
		chkq(sbu_target_model_i.rxQ, 8'h18);
		chk(hostQ.size(), n);
		for (int k = 0; k < n; k++) chkq(hostQ, 8'(k));
		chk(32'({permit, permitOe}), 32'h3);
	endtask
	// closed gate blocks both directions
	task automatic s_gate;
		gate <= 1'b0;
		wt(10);
		sbu_target_model_i.send(8'h66);
		hsend(8'h24);
		wt(150);
		chk(hostQ.size() + sbu_target_model_i.rxQ.size(), 0);
		gate <= 1'b1;
		wt(150);
		chkq(sbu_target_model_i.rxQ, 8'h24);
		chk(hostQ.size(), 0);
	endtask
	initial
	begin
		wt(8);
		srst <= 1'b0;
		s_reset();
		s_path();
		s_in();
		s_full();
		s_gate();
		report_and_stop();
	end
endmodule
`default_nettype wire
